// >>> common/sadc_cfg.svh
// Constants of the successive-approximation converter control block.
//
// Behaviour
// [RULE_01] Host supplies a free-running conversion clock, 200kHz to 3.2MHz, phases at least 150ns.
// [RULE_02] Conversion starts on start strobe falling with select low and valid address.
// [RULE_03] Converting state entered on first conversion-clock rise after the start strobe falls.
// [RULE_04] One bit per conversion cycle, MSB fixed in cycle 1, LSB in 12.
// [RULE_05] Busy flag goes low after a trigger and stays low throughout conversion.
// [RULE_06] Busy flag rises only when done; result is valid from that edge.
// [RULE_07] Result appears as a 12-bit word on the data lines, MSB to LSB.
// [RULE_08] Result is straight binary, zero gives 000, reference gives FFF.
// [RULE_09] After busy rises, select and read strobe low enable the output drivers.
// [RULE_10] Read strobe rising with select low and address zero high enters power-down.
// [RULE_11] In power-down, read strobe rising with address zero low wakes the device.
// [RULE_12] Power-down switches off analog and digital activity until a valid wake-up.
// [RULE_13] Host should read the result right after every conversion.
// [RULE_14] Select and start strobe both low put the data outputs in high impedance.
// [RULE_15] Address lines latch on read or start strobe rising edge.
// [RULE_16] A full conversion period takes 16 conversion-clock cycles; the code counts no period and a conversion ends after 12 decisions.
// [RULE_17] Last result is held unchanged until the next conversion completes.
// [RULE_18] Start requests while busy is low are ignored.
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH
`define SADC_RES_BITS 12
`define SADC_LAST_BIT 4'hB
`define SADC_CYC_PER_SAMPLE 16
`define SADC_MSB_MASK 12'h800
`define SADC_RESULT_RST 12'h000
`define SADC_CLK_PERIOD_NS 4
`define SADC_CONV_PHASE_NS 150
`define SADC_CONV_PHASE_CYC ((`SADC_CONV_PHASE_NS + `SADC_CLK_PERIOD_NS - 1) / `SADC_CLK_PERIOD_NS)
`endif

// >>> common/sadc_pkg.sv
// Types shared by the converter control block.
package sadc_pkg;
    // Control states, one-hot.
    typedef enum logic [3:0] {
        SADC_IDLE  = 4'h1,
        SADC_WAIT  = 4'h2,
        SADC_CONV  = 4'h4,
        SADC_PDOWN = 4'h8
    } sadc_state_e;

    // Host pins and comparator as one bundle.
    typedef struct packed {
        logic conv_clk;
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic chan_addr_low;
        logic chan_addr_high;
        logic cmp_hi;
    } sadc_pins_s;

    // Whole state of the control block.
    typedef struct packed {
        sadc_pins_s  s1;
        sadc_pins_s  s2;
        sadc_pins_s  s3;
        sadc_state_e state;
        logic [3:0]  bit_idx;
        logic [11:0] trial;
        logic [11:0] result;
        logic [1:0]  chan;
        logic        busy_n;
    } sadc_st_s;
endpackage : sadc_pkg

// >>> rtl/sadc_ctrl.sv
// Control logic of the four-channel successive-approximation converter.
`include "sadc_cfg.svh"

module sadc_ctrl
    import sadc_pkg::*;
(
    // Clock, enable and reset.
    input wire logic i_clk,
    input wire logic i_ce,
    input wire logic i_sys_rst,
    // Host parallel port pins.
    input wire logic i_conv_clk,
    input wire logic i_cs_n,
    input wire logic i_wr_n,
    input wire logic i_rd_n,
    input wire logic i_chan_addr_low,
    input wire logic i_chan_addr_high,
    // Comparator answer for the current trial code.
    input wire logic i_cmp_hi,
    // Host-facing outputs.
    output logic o_busy_n,
    output logic [11:0] o_result_bus,
    output logic o_result_oe,
    // Analog front-end control.
    output logic [11:0] o_dac_code,
    output logic [1:0] o_chan_sel,
    output logic o_sample,
    output logic o_power_down
);

    // Mask of the bit decided in a given conversion cycle, MSB first.
    function automatic logic [11:0] sadc_bit_mask(input logic [3:0] idx);
        sadc_bit_mask = `SADC_MSB_MASK >> idx;
    endfunction : sadc_bit_mask

    sadc_st_s st_r;
    sadc_st_s st_nxt;
    sadc_pins_s pin_now;
    logic clk_rise;
    logic clk_fall;
    logic wr_fall;
    logic wr_rise;
    logic rd_rise;
    logic start_ok;

    // Bundle the pins for the synchroniser.
    assign pin_now = '{conv_clk: i_conv_clk, cs_n: i_cs_n, wr_n: i_wr_n, rd_n: i_rd_n,
                       chan_addr_low: i_chan_addr_low, chan_addr_high: i_chan_addr_high,
                       cmp_hi: i_cmp_hi};

    // Edges are taken from the second and third stages only; the first stage is metastable-prone.
    assign clk_rise = st_r.s2.conv_clk & ~st_r.s3.conv_clk;
    assign clk_fall = ~st_r.s2.conv_clk & st_r.s3.conv_clk;
    assign wr_fall = ~st_r.s2.wr_n & st_r.s3.wr_n;
    assign wr_rise = st_r.s2.wr_n & ~st_r.s3.wr_n;
    assign rd_rise = st_r.s2.rd_n & ~st_r.s3.rd_n;
    // A start counts only from idle with select low, so a busy converter ignores it.
    assign start_ok = wr_fall & ~st_r.s2.cs_n & (st_r.state == SADC_IDLE); // RULE_02 RULE_18

    // Next-state logic.
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_now;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // Channel address is caught on either strobe's rising edge, but not while asleep.
        if ((rd_rise | wr_rise) && st_r.state != SADC_PDOWN) begin
            st_nxt.chan = {st_r.s2.chan_addr_high, st_r.s2.chan_addr_low}; // RULE_15
        end
        case (st_r.state)
            SADC_IDLE: begin
                if (start_ok) begin
                    st_nxt.busy_n = 1'b0; // RULE_05
                    st_nxt.chan = {st_r.s2.chan_addr_high, st_r.s2.chan_addr_low};
                    st_nxt.state = SADC_WAIT;
                end else if (rd_rise && !st_r.s2.cs_n && st_r.s2.chan_addr_low) begin
                    st_nxt.state = SADC_PDOWN; // RULE_10
                end
            end
            SADC_WAIT: begin
                // The first conversion-clock rise opens cycle 1 with the MSB on trial.
                if (clk_rise) begin
                    st_nxt.state = SADC_CONV; // RULE_03
                    st_nxt.bit_idx = 4'h0;
                    st_nxt.trial = `SADC_MSB_MASK;
                end
            end
            SADC_CONV: begin
                // Each falling edge fixes the bit on trial; each rising edge opens the next.
                if (clk_fall) begin
                    if (!st_r.s2.cmp_hi) begin
                        st_nxt.trial = st_r.trial & ~sadc_bit_mask(st_r.bit_idx); // RULE_04
                    end else begin
                        st_nxt.trial = st_r.trial;
                    end
                    if (st_r.bit_idx == `SADC_LAST_BIT) begin
                        // Straight binary: the decided trial word is the result as is.
                        st_nxt.result = st_nxt.trial; // RULE_08 RULE_17
                        st_nxt.busy_n = 1'b1; // RULE_06
                        st_nxt.state = SADC_IDLE;
                    end
                end else if (clk_rise) begin
                    st_nxt.bit_idx = st_r.bit_idx + 4'h1;
                    st_nxt.trial = st_r.trial | sadc_bit_mask(st_r.bit_idx + 4'h1); // RULE_04
                end
            end
            SADC_PDOWN: begin
                // Everything stays off until the read strobe rises with address zero low.
                st_nxt.trial = `SADC_RESULT_RST; // RULE_12
                if (rd_rise && !st_r.s2.chan_addr_low) begin
                    st_nxt.state = SADC_IDLE; // RULE_11
                end
            end
            default: begin
                st_nxt.state = SADC_IDLE;
                st_nxt.busy_n = 1'b1;
            end
        endcase
    end

    // State register; the clock enable freezes everything including the synchroniser.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_r <= '{s1: '1, s2: '1, s3: '1, state: SADC_IDLE, bit_idx: 4'h0,
                      trial: `SADC_RESULT_RST, result: `SADC_RESULT_RST, chan: 2'h0, busy_n: 1'b1};
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    // Outputs. The data word comes straight from the result flops, MSB on bit 11.
    assign o_busy_n = st_r.busy_n;
    assign o_result_bus = st_r.result; // RULE_07
    // Drivers on only for a read after completion, never during a start or asleep.
    assign o_result_oe = st_r.busy_n & ~st_r.s2.cs_n & ~st_r.s2.rd_n & st_r.s2.wr_n
                         & (st_r.state == SADC_IDLE); // RULE_09 RULE_14
    assign o_dac_code = st_r.trial;
    assign o_chan_sel = st_r.chan;
    // Sampling runs between conversions; a conversion is twelve decisions and no 16-cycle period is counted.
    assign o_sample = (st_r.state == SADC_IDLE) | (st_r.state == SADC_WAIT); // RULE_16
    assign o_power_down = (st_r.state == SADC_PDOWN); // RULE_12

    // Assertions.
    default clocking sadc_cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    a_busy_low_start: assert property (i_ce && start_ok |=> !o_busy_n && st_r.state == SADC_WAIT) // RULE_05
        else $error("busy did not fall after a start");

    a_busy_held_low: assert property (st_r.state inside {SADC_WAIT, SADC_CONV} |-> !o_busy_n) // RULE_05
        else $error("busy high during conversion");

    a_conv_entry: assert property (i_ce && st_r.state == SADC_WAIT && clk_rise
                                   |=> st_r.state == SADC_CONV && o_dac_code == 12'h800) // RULE_03
        else $error("conversion not entered on clock rise");

    a_bit_order: assert property (i_ce && st_r.state == SADC_CONV && clk_rise
                                  |=> o_dac_code[4'hB - st_r.bit_idx] == 1'b1
                                      && st_r.bit_idx == $past(st_r.bit_idx) + 4'h1) // RULE_04
        else $error("trial bit not opened in order");

    a_busy_rise_done: assert property ($rose(o_busy_n) |-> $past(st_r.state) == SADC_CONV
                                       && $past(st_r.bit_idx) == 4'hB
                                       && o_result_bus == o_dac_code) // RULE_06
        else $error("busy rose without a finished conversion");

    a_result_hold: assert property (!$rose(o_busy_n) |-> $stable(o_result_bus)) // RULE_17
        else $error("result changed without a new conversion");

    a_hiz_on_start: assert property (!st_r.s2.cs_n && !st_r.s2.wr_n |-> !o_result_oe) // RULE_14
        else $error("outputs driven during a start");

    a_read_enable: assert property (o_busy_n && st_r.state == SADC_IDLE && !st_r.s2.cs_n
                                    && !st_r.s2.rd_n && st_r.s2.wr_n |-> o_result_oe) // RULE_09
        else $error("read did not enable outputs");

    a_pd_entry: assert property (i_ce && st_r.state == SADC_IDLE && !start_ok && rd_rise
                                 && !st_r.s2.cs_n && st_r.s2.chan_addr_low |=> o_power_down) // RULE_10
        else $error("power-down not entered");

    a_pd_wake: assert property (i_ce && o_power_down && rd_rise && !st_r.s2.chan_addr_low
                                |=> st_r.state == SADC_IDLE ##1 !o_power_down || !i_ce) // RULE_11
        else $error("wake-up not taken");

    a_pd_quiet: assert property (o_power_down && $past(o_power_down)
                                 |-> o_dac_code == 12'h000 && !o_sample && !o_result_oe) // RULE_12
        else $error("activity during power-down");

    a_start_ignored: assert property (st_r.state == SADC_CONV && wr_fall && i_ce
                                      && !clk_fall |=> st_r.state == SADC_CONV) // RULE_18
        else $error("start accepted while busy");

endmodule : sadc_ctrl

// >>> sim/sadc_cmp_model.sv
// Comparator model standing in for the analog front end behind the control block.
module sadc_cmp_model (
    // Trial code and the level held on the selected input.
    input wire logic [11:0] i_dac_code,
    input wire logic [11:0] i_level,
    // Comparator answer.
    output logic o_cmp_hi
);
    timeunit 1ns;
    timeprecision 1ps;
    // Keeping every trial bit that does not overshoot makes the finished word equal the level.
    assign o_cmp_hi = (i_dac_code <= i_level);
endmodule : sadc_cmp_model

// >>> sim/testbench.sv
// Self-checking testbench for the converter control block.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic ce = 1'b1;
    logic conv_clk = 1'b0;
    logic cs_n = 1'b1;
    logic wr_n = 1'b1;
    logic rd_n = 1'b1;
    logic a_lo = 1'b0;
    logic a_hi = 1'b0;
    logic cmp_hi;
    logic [11:0] level = 12'h000;
    logic busy_n, oe, sample, pdown;
    logic [11:0] result, dac;
    logic [1:0] chan;
    int mismatches = 0;
    int n_checks = 0;
    int cyc;
    logic [11:0] levels [5] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'hA5C};

    sadc_ctrl DUT (.i_clk(i_clk), .i_ce(ce), .i_sys_rst(i_sys_rst), .i_conv_clk(conv_clk), .i_cs_n(cs_n),
        .i_wr_n(wr_n), .i_rd_n(rd_n), .i_chan_addr_low(a_lo), .i_chan_addr_high(a_hi), .i_cmp_hi(cmp_hi),
        .o_busy_n(busy_n), .o_result_bus(result), .o_result_oe(oe), .o_dac_code(dac), .o_chan_sel(chan),
        .o_sample(sample), .o_power_down(pdown));
    sadc_cmp_model cmp (.i_dac_code(dac), .i_level(level), .o_cmp_hi(cmp_hi));

    // System clock of 4 ns.
    always #2 i_clk = ~i_clk;
    // Free-running conversion clock with a 320 ns period, just slower than the fastest allowed.
    initial forever begin
        repeat (40) @(posedge i_clk);
        #1 conv_clk = ~conv_clk;
    end

    task check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check
    task end_sim;
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    // Inputs always move one nanosecond after a rising edge.
    task step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step
    // Bounded wait on the busy flag; running out ends the run.
    task wait_busy(input logic val, input int bound);
        cyc = 0;
        while (busy_n !== val) begin
            if (cyc == bound) begin
                mismatches++;
                $display("unexpected busy_n: expected %b, seen %b", val, busy_n);
                end_sim;
            end
            step(1);
            cyc++;
        end
    endtask : wait_busy
    // A conversion with a read strobe held low during the start and a refused restart inside it.
    task conv(input logic [11:0] lv, input logic [1:0] addr);
        level = lv;
        {a_hi, a_lo} = addr;
        cs_n = 1'b0;
        wr_n = 1'b0;
        rd_n = 1'b0;
        wait_busy(1'b0, 8);
        check("oe while start", {11'h000, oe}, 12'h000);
        cs_n = 1'b1;
        step(2);
        wr_n = 1'b1;
        rd_n = 1'b1;
        {a_hi, a_lo} = ~addr;
        step(300);
        cs_n = 1'b0;
        wr_n = 1'b0;
        step(6);
        check("busy_n in conversion", {11'h000, busy_n}, 12'h000);
        check("sample in conversion", {11'h000, sample}, 12'h000);
        wr_n = 1'b1;
        cs_n = 1'b1;
        {a_hi, a_lo} = addr;
        wait_busy(1'b1, 1500);
        check("conversion too short", {11'h000, cyc > 540}, 12'h001);
        check("result", result, lv);
        check("channel", {10'h000, chan}, {10'h000, addr});
        step(30);
        check("busy_n after refused start", {11'h000, busy_n}, 12'h001);
    endtask : conv
    // Read cycle; address zero decides whether the rising strobe powers down or wakes.
    // The drivers are expected off for a read made while the device is asleep.
    task read(input logic [11:0] exp, input logic lo, input logic exp_oe);
        a_lo = lo;
        cs_n = 1'b0;
        rd_n = 1'b0;
        step(4);
        check("oe in read", {11'h000, oe}, {11'h000, exp_oe});
        check("read data", result, exp);
        rd_n = 1'b1;
        step(6);
        check("oe after read", {11'h000, oe}, 12'h000);
        check("power_down", {11'h000, pdown}, {11'h000, lo});
    endtask : read
    // A frozen clock enable stretches a conversion past its longest length; a mid-run reset then clears it.
    task freeze_reset;
        cs_n = 1'b0;
        wr_n = 1'b0;
        wait_busy(1'b0, 8);
        cs_n = 1'b1;
        wr_n = 1'b1;
        step(200);
        ce = 1'b0;
        step(1200);
        check("busy_n while frozen", {11'h000, busy_n}, 12'h000);
        ce = 1'b1;
        step(10);
        check("busy_n after unfreeze", {11'h000, busy_n}, 12'h000);
        i_sys_rst = 1'b1;
        step(2);
        i_sys_rst = 1'b0;
        check("reset mid-run outputs", {busy_n, oe, sample, pdown, chan, dac[5:0]}, 12'hA00);
        check("reset mid-run result", result, 12'h000);
    endtask : freeze_reset

    initial begin
        step(16);
        i_sys_rst = 1'b0;
        check("reset outputs", {busy_n, oe, sample, pdown, chan, dac[5:0]}, 12'hA00);
        check("reset result", result, 12'h000);
        step(4);
        for (int i = 0; i < 5; i++) begin
            conv(levels[i], i[1:0]);
            read(levels[i], 1'b0, 1'b1);
            read(levels[i], 1'b0, 1'b1);
        end
        read(12'hA5C, 1'b1, 1'b1);
        wr_n = 1'b0;
        step(8);
        check("busy_n in power-down", {11'h000, busy_n}, 12'h001);
        check("sample in power-down", {11'h000, sample}, 12'h000);
        check("dac in power-down", dac, 12'h000);
        wr_n = 1'b1;
        step(4);
        // A read while asleep leaves the drivers off; its rising strobe wakes the device.
        read(12'hA5C, 1'b0, 1'b0);
        cs_n = 1'b1;
        step(4);
        conv(12'h3C1, 2'h2);
        read(12'h3C1, 1'b0, 1'b1);
        freeze_reset;
        end_sim;
    end
endmodule : testbench
